//--- core/pscmd_handler.sv
// parameter-store command handler: frame intake, store/restore, global banks
// assumes byte stream and side ports come from logic on clk; nvm in flip-flops
//
// Behaviour
// - instr 7 stores axis parameter to nvm
// - instr 8 reloads axis parameter from nvm
// - power up loads all axis parameters first
// - instr 9 writes global parameter, banks 0/2/3
// - banks: settings 0, user 2, irq 3
// - bank 0 writes commit to nvm automatically
// - instr 10 reads global into accumulator in standalone mode
// - direct read replies OK with value
// - instr 11 bank 2 stores user variable
// - user variables restore automatically or on request
// - direct read leaves accumulator unchanged
`timescale 1ns/10ps
`include "pscmd_defs.svh"
module pscmd_handler #(
  parameter logic [7:0] MODULE_ADDRESS = 8'h01,
  parameter logic [7:0] HOST_ADDRESS   = 8'h02,
  parameter int         NUM_AXIS       = 256,
  parameter int         NUM_GLOBAL     = 256
) (
  input  wire logic                      clk,
  input  wire logic                      resetn,
  input  wire logic                      nvmClearn,
  input  wire logic                      ce,
  input  wire logic                      rxValid,
  input  wire logic [7:0]                rxData,
  output logic                           rxReady,
  output logic                           replyValid,
  input  wire logic                      replyReady,
  output pscmd_pkg::pscmd_reply_type     reply,
  input  wire logic                      standaloneMode,
  input  wire logic                      autoRestoreUser,
  output logic [31:0]                    accumulator,
  output logic                           bootDone,
  input  wire logic                      axisWrEn,
  input  wire logic [7:0]                axisWrIndex,
  input  wire logic [31:0]               axisWrData,
  input  wire logic [7:0]                axisRdIndex,
  output logic [31:0]                    axisRdData
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [7:0] byteSum(input logic [63:0] bytes);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < 8; i++) s = s + bytes[i*8 +: 8];
    return s;
  endfunction : byteSum

  function automatic logic globalBankOk(input logic [7:0] bank);
    return (bank == `PSCMD_BANK_SETTINGS) || (bank == `PSCMD_BANK_USER) || (bank == `PSCMD_BANK_IRQ);
  endfunction : globalBankOk

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  pscmd_pkg::pscmd_state_type state;
  pscmd_pkg::pscmd_state_type next_state;
  pscmd_pkg::pscmd_frame_type frame;
  logic [3:0]                 byteCount;
  logic [8:0]                 bootIndex;
  logic [7:0]                 nextStatus;
  logic [31:0]                nextValue;

  logic [31:0] axisParam [NUM_AXIS];
  logic [31:0] bankSettings [NUM_GLOBAL];
  logic [31:0] bankUser [NUM_GLOBAL];
  logic [31:0] bankIrq [NUM_GLOBAL];

  // ----------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------
  wire        frameDone    = (state == pscmd_pkg::PSCMD_RECEIVE) && rxValid && (byteCount == `PSCMD_LAST_BYTE);
  wire        addressedNow = frame[63:56] == MODULE_ADDRESS;
  wire        exec         = (state == pscmd_pkg::PSCMD_EXECUTE);
  wire        checksumOk   = byteSum(frame[71:8]) == frame.checksum;
  wire [7:0]  idx          = frame.ptype;
  wire        axisTypeOk   = 32'(idx) < NUM_AXIS;
  wire        globTypeOk   = 32'(idx) < NUM_GLOBAL;
  wire        isStoreAxis  = frame.instr == `PSCMD_STORE_AXIS_PARAM_CMD;
  wire        isRestAxis   = frame.instr == `PSCMD_RESTORE_AXIS_PARAM_CMD;
  wire        isSetGlob    = frame.instr == `PSCMD_SET_GLOBAL_PARAM_CMD;
  wire        isGetGlob    = frame.instr == `PSCMD_GET_GLOBAL_PARAM_CMD;
  wire        isStoreGlob  = frame.instr == `PSCMD_STORE_GLOBAL_PARAM_CMD;
  wire        isRestGlob   = frame.instr == `PSCMD_RESTORE_GLOBAL_PARAM_CMD;
  wire        isAxisCmd    = isStoreAxis || isRestAxis;
  wire        isUserCmd    = isStoreGlob || isRestGlob;
  wire        isGlobCmd    = isSetGlob || isGetGlob;
  wire        knownCmd     = isAxisCmd || isGlobCmd || isUserCmd;
  wire        bankOk       = isAxisCmd ? (frame.bank == `PSCMD_BANK_AXIS) :
                             isGlobCmd ? globalBankOk(frame.bank) :
                                         (frame.bank == `PSCMD_BANK_USER);
  wire        typeOk       = isAxisCmd ? axisTypeOk : globTypeOk;
  wire        cmdOk        = exec && checksumOk && knownCmd && bankOk && typeOk;
  wire        bankIsSet    = frame.bank == `PSCMD_BANK_SETTINGS;
  wire        bankIsUser   = frame.bank == `PSCMD_BANK_USER;
  wire [31:0] globRead     = bankIsSet ? bankSettings[idx] : bankIsUser ? bankUser[idx] : bankIrq[idx];

  always_comb begin
    nextStatus = `PSCMD_STATUS_OK;
    nextValue  = `PSCMD_VALUE_NONE;
    if (!checksumOk) begin
      nextStatus = `PSCMD_STATUS_CHECKSUM;
    end else if (!knownCmd) begin
      nextStatus = `PSCMD_STATUS_BAD_CMD;
    end else if (!bankOk) begin
      nextStatus = `PSCMD_STATUS_BAD_VALUE;
    end else if (!typeOk) begin
      nextStatus = `PSCMD_STATUS_BAD_TYPE;
    end else if (isGetGlob && !standaloneMode) begin
      nextValue = globRead;
    end
  end

  // ----------------------------------------------------------------------
  // nvm ports
  // ----------------------------------------------------------------------
  wire        booting      = (state == pscmd_pkg::PSCMD_BOOT_READ) || (state == pscmd_pkg::PSCMD_BOOT_WRITE);
  wire        bootRead     = state == pscmd_pkg::PSCMD_BOOT_READ;
  wire        bootWrite    = state == pscmd_pkg::PSCMD_BOOT_WRITE;
  wire        bootAxisSlot = 32'(bootIndex[7:0]) < NUM_AXIS && !bootIndex[8];
  wire        bootUserSlot = bootIndex[8] == `PSCMD_NVM_SEL_USER;
  wire        restoreState = state == pscmd_pkg::PSCMD_RESTORE;

  wire        axisNvmWr    = cmdOk && isStoreAxis;
  wire        axisNvmRd    = bootRead || (cmdOk && isRestAxis);
  wire [7:0]  axisNvmRdA   = booting ? bootIndex[7:0] : idx;
  wire        globSetWr    = cmdOk && isSetGlob && bankIsSet;
  wire        globUserWr   = cmdOk && isStoreGlob;
  wire        globNvmWr    = globSetWr || globUserWr;
  wire [8:0]  globNvmWrA   = {globUserWr ? `PSCMD_NVM_SEL_USER : `PSCMD_NVM_SEL_SETTINGS, idx};
  wire [31:0] globNvmWrD   = globUserWr ? bankUser[idx] : frame.value;
  wire        globNvmRd    = bootRead || (cmdOk && isRestGlob);
  wire [8:0]  globNvmRdA   = booting ? bootIndex : {`PSCMD_NVM_SEL_USER, idx};
  wire [31:0] axisNvmData;
  wire [31:0] globNvmData;

  pscmd_nvm_store #(.WIDTH(32), .DEPTH(256)) axisNvm (
    .clk    (clk),
    .clearn (nvmClearn),
    .ce     (ce),
    .wrEn   (axisNvmWr),
    .wrAddr (idx),
    .wrData (axisParam[idx]),
    .rdEn   (axisNvmRd),
    .rdAddr (axisNvmRdA),
    .rdData (axisNvmData)
  );

  pscmd_nvm_store #(.WIDTH(32), .DEPTH(512)) globNvm (
    .clk    (clk),
    .clearn (nvmClearn),
    .ce     (ce),
    .wrEn   (globNvmWr),
    .wrAddr (globNvmWrA),
    .wrData (globNvmWrD),
    .rdEn   (globNvmRd),
    .rdAddr (globNvmRdA),
    .rdData (globNvmData)
  );

  // ----------------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      pscmd_pkg::PSCMD_BOOT_READ:  next_state = pscmd_pkg::PSCMD_BOOT_WRITE;
      pscmd_pkg::PSCMD_BOOT_WRITE: next_state = (&bootIndex) ? pscmd_pkg::PSCMD_RECEIVE
                                                             : pscmd_pkg::PSCMD_BOOT_READ;
      pscmd_pkg::PSCMD_RECEIVE: begin
        // frames for other addresses are dropped without a reply
        if (frameDone && addressedNow) next_state = pscmd_pkg::PSCMD_EXECUTE;
      end
      pscmd_pkg::PSCMD_EXECUTE: next_state = (cmdOk && (isRestAxis || isRestGlob)) ? pscmd_pkg::PSCMD_RESTORE
                                                                                 : pscmd_pkg::PSCMD_REPLY;
      pscmd_pkg::PSCMD_RESTORE: next_state = pscmd_pkg::PSCMD_REPLY;
      pscmd_pkg::PSCMD_REPLY:   if (replyReady) next_state = pscmd_pkg::PSCMD_RECEIVE;
      default:                  next_state = pscmd_pkg::PSCMD_BOOT_READ;
    endcase
  end

  assign rxReady    = state == pscmd_pkg::PSCMD_RECEIVE;
  assign replyValid = state == pscmd_pkg::PSCMD_REPLY;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state     <= pscmd_pkg::PSCMD_BOOT_READ;
      bootIndex <= '0;
      bootDone  <= 1'b0;
    end else if (ce) begin
      state     <= next_state;
      if (bootWrite) bootIndex <= bootIndex + 9'(`PSCMD_COUNT_ONE);
      if (next_state == pscmd_pkg::PSCMD_RECEIVE) bootDone <= 1'b1;
    end
  end

  // frame intake, first byte ends in the top field
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      frame     <= '0;
      byteCount <= `PSCMD_COUNT_ZERO;
    end else if (ce && rxReady && rxValid) begin
      frame     <= {frame[63:0], rxData};
      byteCount <= frameDone ? `PSCMD_COUNT_ZERO : byteCount + `PSCMD_COUNT_ONE;
    end
  end

  // ----------------------------------------------------------------------
  // reply and accumulator
  // ----------------------------------------------------------------------
  wire [63:0] replyBody = {HOST_ADDRESS, MODULE_ADDRESS, nextStatus, frame.instr, nextValue};

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reply       <= '0;
      accumulator <= '0;
    end else if (ce && exec) begin
      reply <= {replyBody, byteSum(replyBody)};
      if (cmdOk && isGetGlob && standaloneMode) accumulator <= globRead;
    end
  end

  // ----------------------------------------------------------------------
  // working parameters
  // ----------------------------------------------------------------------
  // restore and boot load win over the side write port in the same cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < NUM_AXIS; i++) axisParam[i] <= '0;
    end else if (ce) begin
      if (bootWrite && bootAxisSlot) begin
        axisParam[bootIndex[7:0]] <= axisNvmData;
      end else if (restoreState && isRestAxis) begin
        axisParam[idx] <= axisNvmData;
      end else if (axisWrEn) begin
        axisParam[axisWrIndex] <= axisWrData;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      axisRdData <= '0;
    end else if (ce) begin
      axisRdData <= axisParam[axisRdIndex];
    end
  end

  wire bootSetSlot = bootWrite && !bootIndex[8] && 32'(bootIndex[7:0]) < NUM_GLOBAL;
  wire bootUsrSlot = bootWrite && bootUserSlot && autoRestoreUser && 32'(bootIndex[7:0]) < NUM_GLOBAL;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < NUM_GLOBAL; i++) begin
        bankSettings[i] <= '0;
        bankUser[i]     <= '0;
        bankIrq[i]      <= '0;
      end
    end else if (ce) begin
      if (bootSetSlot) bankSettings[bootIndex[7:0]] <= globNvmData;
      if (bootUsrSlot) bankUser[bootIndex[7:0]] <= globNvmData;
      if (restoreState && isRestGlob) bankUser[idx] <= globNvmData;
      if (cmdOk && isSetGlob) begin
        if (bankIsSet) bankSettings[idx] <= frame.value;
        else if (bankIsUser) bankUser[idx] <= frame.value;
        else bankIrq[idx] <= frame.value;
      end
    end
  end

endmodule : pscmd_handler

//--- core/pscmd_defs.svh
// constants of the parameter-store command handler
// assumes inclusion by bare name from every design file that needs them
`ifndef PSCMD_DEFS_SVH
`define PSCMD_DEFS_SVH

// ----------------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------------
`define PSCMD_LAST_BYTE          4'h8
`define PSCMD_COUNT_ZERO         4'h0
`define PSCMD_COUNT_ONE          4'h1

// ----------------------------------------------------------------------
// instruction numbers
// ----------------------------------------------------------------------
`define PSCMD_STORE_AXIS_PARAM_CMD     8'h07
`define PSCMD_RESTORE_AXIS_PARAM_CMD   8'h08
`define PSCMD_SET_GLOBAL_PARAM_CMD     8'h09
`define PSCMD_GET_GLOBAL_PARAM_CMD     8'h0A
`define PSCMD_STORE_GLOBAL_PARAM_CMD   8'h0B
`define PSCMD_RESTORE_GLOBAL_PARAM_CMD 8'h0C

// ----------------------------------------------------------------------
// banks
// ----------------------------------------------------------------------
`define PSCMD_BANK_AXIS          8'h00
`define PSCMD_BANK_SETTINGS      8'h00
`define PSCMD_BANK_USER          8'h02
`define PSCMD_BANK_IRQ           8'h03
`define PSCMD_NVM_SEL_SETTINGS   1'h0
`define PSCMD_NVM_SEL_USER       1'h1

// ----------------------------------------------------------------------
// reply status codes
// ----------------------------------------------------------------------
`define PSCMD_STATUS_OK          8'h64
`define PSCMD_STATUS_CHECKSUM    8'h01
`define PSCMD_STATUS_BAD_CMD     8'h02
`define PSCMD_STATUS_BAD_TYPE    8'h03
`define PSCMD_STATUS_BAD_VALUE   8'h04
`define PSCMD_VALUE_NONE         32'h0000_0000

`endif

//--- core/pscmd_pkg.sv
// types of the parameter-store command handler
// assumes pscmd_defs.svh is compiled alongside
package pscmd_pkg;

  // --------------------------------------------------------------------
  // frames and states
  // --------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  target;
    logic [7:0]  instr;
    logic [7:0]  ptype;
    logic [7:0]  bank;
    logic [31:0] value;
    logic [7:0]  checksum;
  } pscmd_frame_type;

  typedef struct packed {
    logic [7:0]  hostAddr;
    logic [7:0]  targetAddr;
    logic [7:0]  status;
    logic [7:0]  instr;
    logic [31:0] value;
    logic [7:0]  checksum;
  } pscmd_reply_type;

  typedef enum logic [2:0] {
    PSCMD_BOOT_READ  = 3'h0,
    PSCMD_BOOT_WRITE = 3'h1,
    PSCMD_RECEIVE    = 3'h2,
    PSCMD_EXECUTE    = 3'h3,
    PSCMD_RESTORE    = 3'h4,
    PSCMD_REPLY      = 3'h5
  } pscmd_state_type;

endpackage : pscmd_pkg

//--- core/pscmd_nvm_store.sv
// non-volatile parameter store held in flip-flops
// assumes one clock; clearn models the blank part, resetn does not touch it
`timescale 1ns/10ps
module pscmd_nvm_store #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 256,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic             clk,
  input  wire logic             clearn,
  input  wire logic             ce,
  input  wire logic             wrEn,
  input  wire logic [AW-1:0]    wrAddr,
  input  wire logic [WIDTH-1:0] wrData,
  input  wire logic             rdEn,
  input  wire logic [AW-1:0]    rdAddr,
  output logic      [WIDTH-1:0] rdData
);

  // ----------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------
  // contents survive the block reset so a reset behaves like a power cycle
  logic [WIDTH-1:0] cells [DEPTH];

  always_ff @(posedge clk or negedge clearn) begin
    if (!clearn) begin
      for (int i = 0; i < DEPTH; i++) cells[i] <= '0;
    end else if (ce && wrEn) begin
      cells[wrAddr] <= wrData;
    end
  end

  // registered read: data is valid one enabled cycle after rdEn
  always_ff @(posedge clk or negedge clearn) begin
    if (!clearn) begin
      rdData <= '0;
    end else if (ce && rdEn) begin
      rdData <= cells[rdAddr];
    end
  end

endmodule : pscmd_nvm_store

//--- verification/pscmd_handler_chk.sv
// port checker of the parameter-store command handler
// assumes ce held high; boot counted in clock cycles
`timescale 1ns/10ps
`include "pscmd_defs.svh"
module pscmd_handler_chk #(
  parameter logic [7:0] MODULE_ADDRESS = 8'h01,
  parameter logic [7:0] HOST_ADDRESS   = 8'h02
) (
  input wire logic                       clk,
  input wire logic                       resetn,
  input wire logic                       rxValid,
  input wire logic [7:0]                 rxData,
  input wire logic                       rxReady,
  input wire logic                       replyValid,
  input wire logic                       replyReady,
  input wire pscmd_pkg::pscmd_reply_type reply,
  input wire logic                       standaloneMode,
  input wire logic [31:0]                accumulator,
  input wire logic                       bootDone
);
  // ----------------------------------------------------------------
  // frame tracking
  // ----------------------------------------------------------------
  logic [3:0]  byteCnt;
  logic        hit;
  logic [10:0] bootCnt;
  wire         take = rxValid && rxReady;
  wire         last = take && byteCnt == `PSCMD_LAST_BYTE;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      byteCnt <= 4'h0;
      hit     <= 1'b0;
      bootCnt <= 11'h000;
    end else begin
      if (take)
        byteCnt <= last ? `PSCMD_COUNT_ZERO : byteCnt + `PSCMD_COUNT_ONE;
      if (take && byteCnt == `PSCMD_COUNT_ZERO)
        hit <= (rxData == MODULE_ADDRESS);
      if (!bootDone)
        bootCnt <= bootCnt + 11'h001;
    end
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  property p_boot_quiet;
    !bootDone |-> !rxReady && !replyValid;
  endproperty
  a_boot_quiet: assert property (p_boot_quiet) else $error("port active in boot");
  // one edge of slack each way
  property p_boot_len;
    $rose(bootDone) |-> bootCnt >= 11'h3FF && bootCnt <= 11'h401;
  endproperty
  a_boot_len: assert property (p_boot_len) else $error("boot load length wrong");
  property p_frame_reply;
    last && hit |=> !rxReady ##[1:2] replyValid;
  endproperty
  a_frame_reply: assert property (p_frame_reply) else $error("no reply after frame");
  property p_stray;
    last && !hit |=> rxReady && !replyValid;
  endproperty
  a_stray: assert property (p_stray) else $error("stray frame answered");
  property p_reply_hold;
    replyValid && !replyReady |=> replyValid && $stable(reply);
  endproperty
  a_reply_hold: assert property (p_reply_hold) else $error("reply changed before taken");
  property p_reply_release;
    replyValid && replyReady |=> !replyValid && rxReady;
  endproperty
  a_reply_release: assert property (p_reply_release) else $error("reply not released");
  property p_reply_frame;
    replyValid |-> reply.hostAddr == HOST_ADDRESS && reply.targetAddr == MODULE_ADDRESS
      && reply.checksum == 8'(reply.hostAddr + reply.targetAddr + reply.status + reply.instr
      + reply.value[31:24] + reply.value[23:16] + reply.value[15:8] + reply.value[7:0]);
  endproperty
  a_reply_frame: assert property (p_reply_frame) else $error("reply header or sum wrong");
  property p_value_zero;
    replyValid && (reply.status != `PSCMD_STATUS_OK || reply.instr != `PSCMD_GET_GLOBAL_PARAM_CMD
      || standaloneMode) |-> reply.value == `PSCMD_VALUE_NONE;
  endproperty
  a_value_zero: assert property (p_value_zero) else $error("reply value not zero");
  property p_ok_known;
    replyValid && reply.status == `PSCMD_STATUS_OK
      |-> reply.instr inside {[`PSCMD_STORE_AXIS_PARAM_CMD:`PSCMD_RESTORE_GLOBAL_PARAM_CMD]};
  endproperty
  a_ok_known: assert property (p_ok_known) else $error("unknown instr ok");
  property p_accum;
    !standaloneMode && !$past(standaloneMode) |-> $stable(accumulator);
  endproperty
  a_accum: assert property (p_accum) else $error("accumulator moved");
endmodule : pscmd_handler_chk
bind pscmd_handler pscmd_handler_chk #(.MODULE_ADDRESS(MODULE_ADDRESS), .HOST_ADDRESS(HOST_ADDRESS))
  u_pscmd_handler_chk (.clk, .resetn, .rxValid, .rxData, .rxReady, .replyValid, .replyReady, .reply,
  .standaloneMode, .accumulator, .bootDone);

//--- verification/pscmd_host.sv
// host model: sends command frames byte by byte and takes replies
// assumes tasks start just after a rising edge
`timescale 1ns/10ps
module pscmd_host (
  input  wire logic                       clk,
  input  wire logic                       rxReady,
  input  wire logic                       replyValid,
  input  wire pscmd_pkg::pscmd_reply_type reply,
  output logic                            rxValid,
  output logic [7:0]                      rxData,
  output logic                            replyReady
);
  initial begin
    rxValid    = 1'b0;
    rxData     = 8'hFF;
    replyReady = 1'b0;
  end
  // ----------------------------------------------------------------
  // frame sender
  // ----------------------------------------------------------------
  task automatic send_frame(input logic [7:0] tgt, ins, ty, bk, input logic [31:0] val, input logic bad);
    logic [7:0] f [9];
    logic       taken;
    f = '{tgt, ins, ty, bk, val[31:24], val[23:16], val[15:8], val[7:0], 8'h00};
    for (int i = 0; i < 8; i++)
      f[8] += f[i];
    f[8] ^= {7'h00, bad};
    rxValid = 1'b1;
    for (int i = 0; i < 9; i++) begin
      rxData = f[i];
      do begin
        @(negedge clk);
        taken = rxReady;
        @(posedge clk);
      end while (!taken);
      #1;
    end
    rxValid = 1'b0;
    // released line shows no stale byte
    rxData = ~f[8];
  endtask : send_frame
  // ----------------------------------------------------------------
  // reply taker, optionally slow
  // ----------------------------------------------------------------
  task automatic take_reply(input int stall, output pscmd_pkg::pscmd_reply_type r, output logic ok);
    ok = 1'b0;
    r  = '0;
    for (int n = 0; n < 30 && !ok; n++) begin
      @(negedge clk);
      ok = replyValid;
    end
    if (ok) begin
      r = reply;
      repeat (stall + 1) @(posedge clk);
      #1;
      replyReady = 1'b1;
    end
    @(posedge clk);
    #1;
    replyReady = 1'b0;
  endtask : take_reply
endmodule : pscmd_host

//--- verification/testbench.sv
// self-checking bench of the parameter-store command handler
// assumes one 25 MHz clock and ce tied high
`timescale 1ns/10ps
`include "pscmd_defs.svh"
module testbench;
  logic                       clk = 1'b0;
  logic                       resetn = 1'b0;
  logic                       nvmClearn = 1'b0;
  logic                       ce = 1'b1;
  logic                       standaloneMode = 1'b0;
  logic                       autoRestoreUser = 1'b0;
  logic                       axisWrEn = 1'b0;
  logic [7:0]                 axisWrIndex = 8'h00;
  logic [31:0]                axisWrData = 32'h0;
  logic [7:0]                 axisRdIndex = 8'h00;
  logic                       rxValid, rxReady, replyValid, replyReady, bootDone, ok;
  logic [7:0]                 rxData;
  logic [31:0]                accumulator, axisRdData;
  pscmd_pkg::pscmd_reply_type reply, rep;
  logic [7:0]                 banks [3] = '{8'h00, 8'h02, 8'h03};
  int                         stall = 0;
  int                         num_errors = 0;
  int                         check_count = 0;
  always #20 clk = ~clk;
  pscmd_handler u_pscmd_handler (.clk, .resetn, .nvmClearn, .ce, .rxValid, .rxData, .rxReady, .replyValid,
    .replyReady, .reply, .standaloneMode, .autoRestoreUser, .accumulator, .bootDone, .axisWrEn, .axisWrIndex,
    .axisWrData, .axisRdIndex, .axisRdData);
  pscmd_host u_pscmd_host (.clk, .rxReady, .replyValid, .reply, .rxValid, .rxData, .replyReady);
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic do_reset(input logic clear, input logic autoUser);
    resetn = 1'b0;
    nvmClearn = ~clear;
    autoRestoreUser = autoUser;
    repeat (4) @(posedge clk);
    #1;
    resetn = 1'b1;
    nvmClearn = 1'b1;
    for (int n = 0; n < 1100 && bootDone !== 1'b1; n++)
      @(posedge clk) #1;
    chk("rxReady", 32'h1, {31'h0, rxReady});
  endtask : do_reset
  task automatic cmd(input logic [7:0] ins, ty, bk, input logic [31:0] val, input logic bad = 1'b0);
    u_pscmd_host.send_frame(8'h01, ins, ty, bk, val, bad);
    u_pscmd_host.take_reply(stall, rep, ok);
    chk("replySeen", 32'h1, {31'h0, ok});
  endtask : cmd
  task automatic st(input logic [7:0] exp);
    chk("status", {24'h0, exp}, {24'h0, rep.status});
  endtask : st
  task automatic get_chk(input logic [7:0] ty, bk, input logic [31:0] exp);
    cmd(`PSCMD_GET_GLOBAL_PARAM_CMD, ty, bk, 32'h0);
    st(`PSCMD_STATUS_OK);
    chk("getValue", exp, rep.value);
  endtask : get_chk
  task automatic axis_wr(input logic [7:0] idx, input logic [31:0] d);
    axisWrEn = 1'b1;
    axisWrIndex = idx;
    axisWrData = d;
    @(posedge clk) #1;
    axisWrEn = 1'b0;
  endtask : axis_wr
  task automatic axis_rd(input logic [7:0] idx, input logic [31:0] exp);
    axisRdIndex = idx;
    @(posedge clk) #1;
    chk("axisRdData", exp, axisRdData);
  endtask : axis_rd
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_axis;
    axis_wr(8'h06, 32'h1234_5678);
    cmd(`PSCMD_STORE_AXIS_PARAM_CMD, 8'h06, 8'h00, 32'hFFFF_FFFF);
    st(`PSCMD_STATUS_OK);
    axis_wr(8'h06, 32'hAAAA_5555);
    cmd(`PSCMD_RESTORE_AXIS_PARAM_CMD, 8'h06, 8'h00, 32'h0);
    st(`PSCMD_STATUS_OK);
    axis_rd(8'h06, 32'h1234_5678);
    axis_wr(8'h06, 32'h0BAD_F00D);
    do_reset(1'b0, 1'b0);
    axis_rd(8'h06, 32'h1234_5678);
    cmd(`PSCMD_STORE_AXIS_PARAM_CMD, 8'h06, 8'h01, 32'h0);
    st(`PSCMD_STATUS_BAD_VALUE);
  endtask : t_axis
  task automatic t_glob;
    for (int i = 0; i < 3; i++) begin
      cmd(`PSCMD_SET_GLOBAL_PARAM_CMD, 8'h42, banks[i], 32'hC0DE_0000 + 32'(i));
      st(`PSCMD_STATUS_OK);
    end
    // slow host
    stall = 3;
    for (int i = 0; i < 3; i++)
      get_chk(8'h42, banks[i], 32'hC0DE_0000 + 32'(i));
    stall = 0;
  endtask : t_glob
  task automatic t_user;
    cmd(`PSCMD_SET_GLOBAL_PARAM_CMD, 8'h2A, 8'h02, 32'h0000_BEEF);
    cmd(`PSCMD_STORE_GLOBAL_PARAM_CMD, 8'h2A, 8'h02, 32'hFFFF_FFFF);
    st(`PSCMD_STATUS_OK);
    cmd(`PSCMD_SET_GLOBAL_PARAM_CMD, 8'h2A, 8'h02, 32'h0000_0BAD);
    cmd(`PSCMD_RESTORE_GLOBAL_PARAM_CMD, 8'h2A, 8'h02, 32'h0);
    get_chk(8'h2A, 8'h02, 32'h0000_BEEF);
    cmd(`PSCMD_SET_GLOBAL_PARAM_CMD, 8'h2A, 8'h02, 32'h0000_0BAD);
    do_reset(1'b0, 1'b1);
    get_chk(8'h42, 8'h00, 32'hC0DE_0000);
    get_chk(8'h2A, 8'h02, 32'h0000_BEEF);
    get_chk(8'h42, 8'h03, 32'h0);
  endtask : t_user
  task automatic t_accum;
    standaloneMode = 1'b1;
    cmd(`PSCMD_GET_GLOBAL_PARAM_CMD, 8'h2A, 8'h02, 32'h0);
    chk("accumulator", 32'h0000_BEEF, accumulator);
    standaloneMode = 1'b0;
    get_chk(8'h42, 8'h00, 32'hC0DE_0000);
    chk("accumulator", 32'h0000_BEEF, accumulator);
  endtask : t_accum
  task automatic t_err;
    cmd(`PSCMD_SET_GLOBAL_PARAM_CMD, 8'h42, 8'h00, 32'h1111_1111, 1'b1);
    st(`PSCMD_STATUS_CHECKSUM);
    cmd(`PSCMD_SET_GLOBAL_PARAM_CMD, 8'h42, 8'h01, 32'h1111_1111);
    st(`PSCMD_STATUS_BAD_VALUE);
    cmd(`PSCMD_STORE_GLOBAL_PARAM_CMD, 8'h2A, 8'h00, 32'h0);
    st(`PSCMD_STATUS_BAD_VALUE);
    cmd(8'h3F, 8'h00, 8'h00, 32'h0);
    st(`PSCMD_STATUS_BAD_CMD);
    u_pscmd_host.send_frame(8'h05, `PSCMD_SET_GLOBAL_PARAM_CMD, 8'h42, 8'h00, 32'h1111_1111, 1'b0);
    u_pscmd_host.take_reply(0, rep, ok);
    chk("strayReply", 32'h0, {31'h0, ok});
    get_chk(8'h42, 8'h00, 32'hC0DE_0000);
  endtask : t_err
  task automatic test_done;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done
  initial begin
    do_reset(1'b1, 1'b0);
    t_axis;
    t_glob;
    t_user;
    t_accum;
    t_err;
    test_done;
  end
  // three boots and twenty-six frames fit
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    test_done;
  end
endmodule : testbench
